/* rtl/bssm_pkg.sv */
package bssm_pkg;

    // ************************************************************
    // Register indices; the byte address is four times the index.
    // ************************************************************
    localparam logic [7:0] IDX_INTERRUPT_ENABLE_PRIORITY_TWO = 8'ha9;
    localparam logic [7:0] IDX_ADC_START_MEASUREMENT         = 8'hd8;
    localparam logic [7:0] IDX_BATTERY_ADC_VALUE             = 8'hdf;
    localparam logic [7:0] IDX_SUPPLY_EVENT_ENABLE           = 8'hec;
    localparam logic [7:0] IDX_TEMP_SUPPLY_DELTA             = 8'hf3;
    localparam logic [7:0] IDX_PERIPHERAL_CONFIG             = 8'hf4;
    localparam logic [7:0] IDX_SWITCHOVER_CONFIG             = 8'hf5;
    localparam logic [7:0] IDX_SUPPLY_EVENT_FLAGS            = 8'hf8;
    localparam logic [7:0] IDX_BATTERY_THRESHOLD             = 8'hfa;
    localparam logic [7:0] IDX_INTERRUPT_PIN_CONFIG          = 8'hff;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int BIT_SUPPLY_IRQ_GLOBAL_ENABLE = 1;
    localparam int BIT_SUPPLY_SOURCE_STATUS     = 6;
    localparam int BIT_SWITCHOVER_DISABLE       = 1;
    localparam int BIT_EXT_IRQ1_LO              = 2;
    localparam int BIT_DC_INPUT                 = 0;
    localparam int BIT_BATTERY                  = 1;
    localparam int BIT_RESTORE                  = 2;
    localparam int BIT_LINE_SAG                 = 3;
    localparam int BIT_SWITCHOVER               = 4;

    localparam logic [1:0] PROG_VDD_ONLY  = 2'h0;
    localparam logic [1:0] PROG_DC_INPUT  = 2'h1;
    localparam logic [1:0] PIN_ENABLE_PAT = 2'h1;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] RST_REG  = 8'h00;
    localparam logic [4:0] RST_FLAG = 5'h00;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int DC_SWITCH_MS    = 30;
    localparam int RESTORE_MS      = 130;
    localparam int DC_SWITCH_CYC   = DC_SWITCH_MS * (CLK_HZ / 1000);
    localparam int RESTORE_CYC     = RESTORE_MS * (CLK_HZ / 1000);
    localparam int ADC_PERIOD_CYC  = 1_000_000;

    typedef enum logic [1:0] {
        BSSM_ON_MAIN      = 2'b00,
        BSSM_DC_WAIT      = 2'b01,
        BSSM_ON_BATTERY   = 2'b10,
        BSSM_RESTORE_WAIT = 2'b11
    } bssm_state_t;

endpackage : bssm_pkg

/* rtl/bssm_top.sv */
`timescale 1ns/1ps
`default_nettype none

module bssm_top
    import bssm_pkg::*;
#(
    parameter int DC_SWITCH_CYCLES = DC_SWITCH_CYC,
    parameter int RESTORE_CYCLES   = RESTORE_CYC,
    parameter int ADC_PERIOD       = ADC_PERIOD_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dc_input_low,
    input  wire logic        main_rail_low,
    input  wire logic        battery_control_pin,
    input  wire logic        dc_adc_done,
    input  wire logic [7:0]  dc_adc_result,
    input  wire logic        battery_adc_done,
    input  wire logic [7:0]  battery_adc_result,
    input  wire logic        line_sag_event,
    output logic             dc_adc_start,
    output logic             internal_switched_supply,
    output logic             supply_monitor_interrupt
);

    // ************************************************************
    // Register bus.
    // ************************************************************
    logic [7:0]  interrupt_enable_priority_two;
    logic [7:0]  supply_event_enable;
    logic [7:0]  temp_supply_delta;
    logic [7:0]  peripheral_config;
    logic [7:0]  switchover_config;
    logic [7:0]  battery_threshold;
    logic [7:0]  interrupt_pin_config;
    logic [7:0]  battery_adc_value;
    logic [4:0]  supply_event_flags;
    logic [7:0]  next_rdata;
    logic        next_err;
    logic [7:0]  idx;
    logic        setup;
    logic        wr;

    assign idx    = paddr[9:2];
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb
    begin
        next_err   = 1'b0;
        next_rdata = 8'h00;
        unique case (idx)
            IDX_INTERRUPT_ENABLE_PRIORITY_TWO: next_rdata = interrupt_enable_priority_two;
            IDX_ADC_START_MEASUREMENT:         next_rdata = 8'h00;
            IDX_BATTERY_ADC_VALUE:             next_rdata = battery_adc_value;
            IDX_SUPPLY_EVENT_ENABLE:           next_rdata = supply_event_enable;
            IDX_TEMP_SUPPLY_DELTA:             next_rdata = temp_supply_delta;
            IDX_PERIPHERAL_CONFIG:
            begin
                next_rdata = peripheral_config;
                next_rdata[BIT_SUPPLY_SOURCE_STATUS] = internal_switched_supply;
            end
            IDX_SWITCHOVER_CONFIG:             next_rdata = switchover_config;
            IDX_SUPPLY_EVENT_FLAGS:            next_rdata = {3'h0, supply_event_flags};
            IDX_BATTERY_THRESHOLD:             next_rdata = battery_threshold;
            IDX_INTERRUPT_PIN_CONFIG:          next_rdata = interrupt_pin_config;
            default:                           next_err   = 1'b1;
        endcase
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0)
        begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= {24'h00_0000, next_rdata};
            pslverr <= next_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_enable_priority_two <= RST_REG;
            supply_event_enable           <= RST_REG;
            temp_supply_delta             <= RST_REG;
            peripheral_config             <= RST_REG;
            switchover_config             <= RST_REG;
            battery_threshold             <= RST_REG;
            interrupt_pin_config          <= RST_REG;
        end
        else if (wr && !pslverr)
        begin
            unique case (idx)
                IDX_INTERRUPT_ENABLE_PRIORITY_TWO: interrupt_enable_priority_two <= pwdata[7:0];
                IDX_SUPPLY_EVENT_ENABLE:           supply_event_enable           <= pwdata[7:0];
                IDX_TEMP_SUPPLY_DELTA:             temp_supply_delta             <= pwdata[7:0];
                IDX_PERIPHERAL_CONFIG:             peripheral_config             <= pwdata[7:0];
                IDX_SWITCHOVER_CONFIG:             switchover_config             <= pwdata[7:0];
                IDX_BATTERY_THRESHOLD:             battery_threshold             <= pwdata[7:0];
                IDX_INTERRUPT_PIN_CONFIG:          interrupt_pin_config          <= pwdata[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // ************************************************************
    // Conversions.
    // ************************************************************
    logic [31:0] adc_timer;
    logic [7:0]  dc_prev;
    logic [7:0]  dc_diff;
    logic        sw_start;

    assign sw_start = wr && !pslverr && idx == IDX_ADC_START_MEASUREMENT;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_timer    <= 32'h0000_0000;
            dc_adc_start <= 1'b0;
        end
        else
        begin
            dc_adc_start <= sw_start || adc_timer == 32'(ADC_PERIOD - 1);
            if (adc_timer == 32'(ADC_PERIOD - 1))
            begin
                adc_timer <= 32'h0000_0000;
            end
            else
            begin
                adc_timer <= adc_timer + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dc_prev           <= RST_REG;
            battery_adc_value <= RST_REG;
        end
        else
        begin
            if (dc_adc_done)
            begin
                dc_prev <= dc_adc_result;
            end
            if (battery_adc_done)
            begin
                battery_adc_value <= battery_adc_result;
            end
        end
    end

    assign dc_diff = (dc_adc_result > dc_prev) ? dc_adc_result - dc_prev
                                               : dc_prev - dc_adc_result;

    // ************************************************************
    // Supply switching.
    // ************************************************************
    bssm_state_t state;
    bssm_state_t next_state;
    logic [31:0] wait_cnt;
    logic        pin_q;
    logic        pin_rise;
    logic        pin_en;
    logic        sw_off;
    logic [1:0]  prog;
    logic        vdd_trig;
    logic        dc_trig;
    logic        restore_ok;
    logic        next_on_main;

    assign prog     = switchover_config[1:0];
    assign sw_off   = switchover_config[BIT_SWITCHOVER_DISABLE];
    assign pin_en   = interrupt_pin_config[BIT_EXT_IRQ1_LO +: 2] == PIN_ENABLE_PAT;
    assign pin_rise = pin_en && battery_control_pin && !pin_q;
    assign vdd_trig = prog == PROG_VDD_ONLY && main_rail_low;
    assign dc_trig  = prog == PROG_DC_INPUT && dc_input_low;
    assign restore_ok = !(prog == PROG_VDD_ONLY && main_rail_low)
                     && !(prog == PROG_DC_INPUT && (dc_input_low || main_rail_low))
                     && !(pin_en && battery_control_pin);

    always_comb
    begin
        next_state = state;
        if (sw_off)
        begin
            next_state = BSSM_ON_MAIN;
        end
        else
        begin
            unique case (state)
                BSSM_ON_MAIN:
                begin
                    if (vdd_trig || pin_rise)
                        next_state = BSSM_ON_BATTERY;
                    else if (dc_trig)
                        next_state = BSSM_DC_WAIT;
                end
                BSSM_DC_WAIT:
                begin
                    if (pin_rise || vdd_trig)
                        next_state = BSSM_ON_BATTERY;
                    else if (!dc_trig)
                        next_state = BSSM_ON_MAIN;
                    else if (wait_cnt == 32'(DC_SWITCH_CYCLES - 1))
                        next_state = BSSM_ON_BATTERY;
                end
                BSSM_ON_BATTERY:
                begin
                    if (restore_ok)
                        next_state = BSSM_RESTORE_WAIT;
                end
                BSSM_RESTORE_WAIT:
                begin
                    if (pin_rise || !restore_ok)
                        next_state = BSSM_ON_BATTERY;
                    else if (wait_cnt == 32'(RESTORE_CYCLES - 1))
                        next_state = BSSM_ON_MAIN;
                end
            endcase
        end
    end

    assign next_on_main = next_state == BSSM_ON_MAIN || next_state == BSSM_DC_WAIT;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state                    <= BSSM_ON_MAIN;
            internal_switched_supply <= 1'b1;
            pin_q                    <= 1'b0;
        end
        else
        begin
            state                    <= next_state;
            internal_switched_supply <= next_on_main;
            pin_q                    <= battery_control_pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wait_cnt <= 32'h0000_0000;
        else if (next_state != state)
            wait_cnt <= 32'h0000_0000;
        else
            wait_cnt <= wait_cnt + 32'h0000_0001;
    end

    // ************************************************************
    // Event flags and shared interrupt.
    // ************************************************************
    logic [4:0] set_ev;
    logic [4:0] clr_ev;

    always_comb
    begin
        set_ev = 5'h00;
        set_ev[BIT_SWITCHOVER] = internal_switched_supply && !next_on_main;
        set_ev[BIT_RESTORE]    = !internal_switched_supply && next_on_main;
        set_ev[BIT_DC_INPUT]   = dc_input_low || dc_adc_done;
        set_ev[BIT_BATTERY]    = battery_adc_done;
        set_ev[BIT_LINE_SAG]   = line_sag_event;
        clr_ev = 5'h00;
        if (wr && !pslverr && idx == IDX_SUPPLY_EVENT_FLAGS)
            clr_ev = ~pwdata[4:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_event_flags <= RST_FLAG;
        else
            supply_event_flags <= (supply_event_flags & ~clr_ev) | set_ev;
    end

    logic dc_delta_event;
    assign dc_delta_event = dc_adc_done && dc_diff > temp_supply_delta;

    logic dc_delta_hit;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dc_delta_hit <= 1'b0;
        else if (dc_delta_event)
            dc_delta_hit <= 1'b1;
        else if (clr_ev[BIT_DC_INPUT])
            dc_delta_hit <= 1'b0;
    end

    assign supply_monitor_interrupt =
        interrupt_enable_priority_two[BIT_SUPPLY_IRQ_GLOBAL_ENABLE]
        && (|(supply_event_flags & supply_event_enable[4:0]));

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_switch_flag_set: assert property ($fell(internal_switched_supply)
        |-> supply_event_flags[BIT_SWITCHOVER])
        else $error("switchover flag missing");
    a_restore_flag_set: assert property ($rose(internal_switched_supply)
        |-> supply_event_flags[BIT_RESTORE])
        else $error("restore flag missing");
    a_disable_holds_main: assert property (sw_off |=> internal_switched_supply)
        else $error("main rail not held");
    a_vdd_low_switch: assert property (!sw_off && prog == PROG_VDD_ONLY
        && main_rail_low && internal_switched_supply ##1 !sw_off
        |-> !internal_switched_supply)
        else $error("no switch on low rail");
    a_no_restore_early: assert property ($rose(internal_switched_supply)
        && !sw_off |-> $past(state) == BSSM_RESTORE_WAIT)
        else $error("restore without wait");
    a_dc_delay_exact: assert property ($past(state) == BSSM_DC_WAIT
        && $fell(internal_switched_supply)
        |-> $past(wait_cnt) == 32'(DC_SWITCH_CYCLES - 1) || $past(pin_rise)
        || $past(vdd_trig))
        else $error("dc delay wrong");
    a_irq_gated: assert property (supply_monitor_interrupt
        |-> interrupt_enable_priority_two[BIT_SUPPLY_IRQ_GLOBAL_ENABLE])
        else $error("interrupt not gated");
    a_flag_latched: assert property (supply_event_flags[BIT_LINE_SAG]
        && !clr_ev[BIT_LINE_SAG] |=> supply_event_flags[BIT_LINE_SAG])
        else $error("sag flag dropped");
    a_status_tracks: assert property (setup && idx == IDX_PERIPHERAL_CONFIG
        |=> prdata[BIT_SUPPLY_SOURCE_STATUS] == $past(internal_switched_supply))
        else $error("status bit wrong");
    a_sag_sets: assert property (line_sag_event |=> supply_event_flags[BIT_LINE_SAG])
        else $error("sag not latched");

    c_switch_to_bat: cover property ($fell(internal_switched_supply));
    c_restore_main: cover property ($rose(internal_switched_supply));
    c_irq_raised: cover property ($rose(supply_monitor_interrupt));
    c_delta_event: cover property (dc_delta_hit);

endmodule : bssm_top

`default_nettype wire

/* testbench/bssm_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Converter side: answers conversion starts, fast or slow.
// ************************************************************
module bssm_adc_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    input  wire logic       bat_req,
    input  wire logic       dc_adc_start,
    output logic            dc_adc_done,
    output logic      [7:0] dc_adc_result,
    output logic            battery_adc_done,
    output logic      [7:0] battery_adc_result
);
    logic [3:0] dly;

    // Results are only valid with their done pulse; otherwise they toggle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dly                <= 4'h0;
            dc_adc_done        <= 1'b0;
            dc_adc_result      <= 8'h00;
            battery_adc_done   <= 1'b0;
            battery_adc_result <= 8'h00;
        end
        else
        begin
            if (dc_adc_start)
                dly <= slow ? 4'h9 : 4'h1;
            else if (dly != 4'h0)
                dly <= dly - 4'h1;
            dc_adc_done        <= (dly == 4'h1);
            dc_adc_result      <= (dly == 4'h1) ? 8'h5a : ~dc_adc_result;
            battery_adc_done   <= bat_req;
            battery_adc_result <= bat_req ? 8'h20 : ~battery_adc_result;
        end
    end
endmodule : bssm_adc_model
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Self-checking bench for the supply switchover monitor.
// ************************************************************
module testbench;
    localparam int DCC = 20;
    localparam int RSC = 30;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        dc_low, rail_low, pin, sag, slow, bat_req;
    logic        adc_go, dc_done, bat_done, sup, irq;
    logic [7:0]  dc_res, bat_res, rd;
    int          err_total, n_compared;

    bssm_top #(.DC_SWITCH_CYCLES(DCC), .RESTORE_CYCLES(RSC), .ADC_PERIOD(50)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dc_input_low(dc_low),
        .main_rail_low(rail_low), .battery_control_pin(pin),
        .dc_adc_done(dc_done), .dc_adc_result(dc_res),
        .battery_adc_done(bat_done), .battery_adc_result(bat_res),
        .line_sag_event(sag), .dc_adc_start(adc_go),
        .internal_switched_supply(sup), .supply_monitor_interrupt(irq));

    bssm_adc_model u_adc (
        .pclk(pclk), .presetn(presetn), .slow(slow), .bat_req(bat_req),
        .dc_adc_start(adc_go), .dc_adc_done(dc_done), .dc_adc_result(dc_res),
        .battery_adc_done(bat_done), .battery_adc_result(bat_res));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk1

    // One APB transfer; request held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                chk1(pready, 1'b1, "pready");
                report_and_stop();
            end
            @(posedge pclk);
        end
        rd = prdata[7:0];
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
        apb(1'b0, idx, 8'h00);
        chk8(rd & m, e, "register");
    endtask : rdc

    task automatic wait_sup(input logic v, input int lim);
        int n;
        n = 0;
        while (sup !== v && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk1(sup, v, "supply source");
        if (sup !== v)
            report_and_stop();
    endtask : wait_sup

    task automatic t_reset;
        logic [7:0] ix [8] = '{8'ha9, 8'hd8, 8'hdf, 8'hec, 8'hf3, 8'hf5, 8'hfa, 8'hff};
        foreach (ix[i])
            rdc(ix[i], 8'h00, 8'hff);
        rdc(8'hf8, 8'h00, 8'hfe);
        rdc(8'hf4, 8'h40, 8'hff);
        apb(1'b0, 8'h10, 8'h00);
        chk1(serr, 1'b1, "unmapped error");
        chk8(rd, 8'h00, "unmapped data");
        wr(8'hf3, 8'ha5);
        rdc(8'hf3, 8'ha5, 8'hff);
        wr(8'hdf, 8'h55);
        rdc(8'hdf, 8'h00, 8'hff);
        chk1(irq, 1'b0, "irq after reset");
        $display("reset test done");
    endtask : t_reset

    task automatic t_rail;
        wr(8'hec, 8'h14);
        rail_low <= 1'b1;
        wait_sup(1'b0, 5);
        rdc(8'hf8, 8'h10, 8'h1e);
        chk1(irq, 1'b0, "irq global off");
        wr(8'ha9, 8'h02);
        chk1(irq, 1'b1, "irq switchover");
        rdc(8'hf4, 8'h00, 8'h40);
        rail_low <= 1'b0;
        repeat (RSC - 5) @(posedge pclk);
        chk1(sup, 1'b0, "restore delay");
        wait_sup(1'b1, 15);
        rdc(8'hf8, 8'h14, 8'h1e);
        wr(8'hf8, 8'h04);
        rdc(8'hf8, 8'h04, 8'h1e);
        chk1(irq, 1'b1, "irq restore");
        wr(8'hf8, 8'h00);
        chk1(irq, 1'b0, "irq cleared");
        $display("rail test done");
    endtask : t_rail

    task automatic t_dc;
        dc_low <= 1'b1;
        repeat (DCC + 5) @(posedge pclk);
        chk1(sup, 1'b1, "dc trigger off");
        rdc(8'hf8, 8'h01, 8'h01);
        dc_low <= 1'b0;
        wr(8'hf5, 8'h01);
        dc_low <= 1'b1;
        repeat (DCC - 4) @(posedge pclk);
        chk1(sup, 1'b1, "dc delay");
        wait_sup(1'b0, 10);
        dc_low   <= 1'b0;
        rail_low <= 1'b1;
        repeat (RSC + 10) @(posedge pclk);
        chk1(sup, 1'b0, "rail still low");
        rail_low <= 1'b0;
        wait_sup(1'b1, RSC + 10);
        wr(8'hf5, 8'h00);
        wr(8'hf8, 8'h00);
        $display("dc test done");
    endtask : t_dc

    task automatic t_pin;
        pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk1(sup, 1'b1, "pin disabled");
        pin <= 1'b0;
        wr(8'hff, 8'h04);
        pin <= 1'b1;
        wait_sup(1'b0, 5);
        repeat (RSC + 10) @(posedge pclk);
        chk1(sup, 1'b0, "pin still high");
        pin <= 1'b0;
        wait_sup(1'b1, RSC + 10);
        wr(8'hff, 8'h00);
        wr(8'hf8, 8'h00);
        $display("pin test done");
    endtask : t_pin

    task automatic t_off;
        wr(8'hf5, 8'h02);
        rail_low <= 1'b1;
        repeat (10) @(posedge pclk);
        chk1(sup, 1'b1, "switchover disabled");
        rdc(8'hf8, 8'h00, 8'h10);
        rail_low <= 1'b0;
        wr(8'hf5, 8'h00);
        $display("disable test done");
    endtask : t_off

    task automatic t_events;
        int n;
        wr(8'hec, 8'h01);
        wr(8'hf8, 8'h00);
        slow <= 1'b1;
        wr(8'hd8, 8'h01);
        n = 0;
        while (adc_go !== 1'b1 && n < 60)
        begin
            @(posedge pclk);
            n++;
        end
        chk1(adc_go, 1'b1, "conversion start");
        if (adc_go !== 1'b1)
            report_and_stop();
        repeat (30) @(posedge pclk);
        rdc(8'hf8, 8'h01, 8'h01);
        chk1(irq, 1'b1, "irq dc result");
        wr(8'hec, 8'h0a);
        wr(8'hf8, 8'h00);
        chk1(irq, 1'b0, "irq masked");
        bat_req <= 1'b1;
        @(posedge pclk);
        bat_req <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(8'hf8, 8'h02, 8'h0a);
        rdc(8'hdf, 8'h20, 8'hff);
        chk1(irq, 1'b1, "irq battery");
        wr(8'hf8, 8'h00);
        sag <= 1'b1;
        @(posedge pclk);
        sag <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(8'hf8, 8'h08, 8'h0a);
        chk1(irq, 1'b1, "irq sag");
        wr(8'ha9, 8'h00);
        chk1(irq, 1'b0, "irq global gate");
        $display("event test done");
    endtask : t_events

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {dc_low, rail_low, pin, sag, slow, bat_req} = 6'h00;
        err_total = 0;
        n_compared = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_rail();
        t_dc();
        t_pin();
        t_off();
        t_events();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
